// >>> cir_pkg.sv
package cir_pkg;

  // ********************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ********************************************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_MODEM_CTRL = 8'h08;
  localparam logic [7:0] OFS_AUX_STATUS = 8'h0C;
  localparam logic [7:0] OFS_TX_CARRIER = 8'h10;
  localparam logic [7:0] OFS_CIR_CONFIG = 8'h14;
  localparam logic [7:0] OFS_RX_DEMOD = 8'h18;
  localparam logic [7:0] OFS_BAUD_DIV = 8'h1C;
  localparam logic [7:0] OFS_MODE = 8'h20;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int ASC_TOUT_BIT = 0;
  localparam int ASC_EOT_BIT = 1;
  localparam int ASC_UNDERRUN_BIT = 2;
  localparam int ASC_RX_ACTIVE_FLAG_BIT = 3;
  localparam int ASC_PULSE_BIT = 4;
  localparam int MCR_DMA_EN_BIT = 2;
  localparam int MCR_DEFER_BIT = 3;
  localparam int CFG_HSC_BIT = 0;
  localparam int CFG_RLC_BIT = 1;
  localparam int CFG_DEMOD_EN_BIT = 2;
  localparam int CFG_TPERIOD_BIT = 3;
  localparam int CFG_TXQ_EN_BIT = 4;
  localparam int MODE_EXT_BIT = 2;

  // ********************************************************************
  // reset values and sizes
  // ********************************************************************
  localparam logic [15:0] BAUD_DIV_RST = 16'h0010;
  localparam logic [7:0] CARRIER_RST = 8'h1A;
  localparam logic [3:0] RX_THRESH = 4'h8;
  localparam logic [4:0] TX_DEFER_LEVEL = 5'h0E;
  localparam int QUEUE_DEPTH = 16;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_MHZ = 125;
  localparam int TOUT_US = 64;
  localparam int TOUT_CYC = TOUT_US * CLK_MHZ;
  localparam int CHAR_BITS = 10;
  localparam int CAR_SCALE = 4;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    MOD_CONT = 2'b00,
    MOD_SIX = 2'b01,
    MOD_EIGHT = 2'b11
  } mod_mode_t;

  typedef enum logic [1:0] {
    OPM_UART = 2'b00,
    OPM_SLOW_IR = 2'b01,
    OPM_CIR = 2'b11,
    OPM_HALF_IR = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_UNDERRUN = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic [7:0] carrier_freq_sel;
    logic [7:0] carrier_pulse_width;
  } carrier_cfg_t;

  typedef struct packed {
    logic [7:0] demod_freq_range;
    logic [7:0] demod_bandwidth;
  } demod_cfg_t;

endpackage

// >>> cir_txrx.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
// How it works
// - cir mode: writing into an empty transmit queue starts sending
// - end flag before last byte, or dma terminal count, ends frame cleanly
// - queue drained without end marker ends frame, raises underrun until cleared
// - bytes go out raw or run-length expanded at baud rate, no framing
// - logic 1 keeps emitter dark; logic 0 pulses from carrier settings
// - modulation select: continuous, or six/eight pulses per 1-to-0 edge
// - short zero run cuts the six/eight pulse burst at run end
// - only modulated output; no unmodulated flash mode
// - receiver starts at once, or only on in-band carrier with demodulation
// - active receiver sets flag, samples at baud, packs bytes or runs
// - pulse-seen flag sets per pulse, clears on status register read
// - in-band window comes from demod range and bandwidth fields
// - period mode resyncs sampling phase on each new energy pulse
// - time-out gives data-ready irq if enabled, dma request in extended mode
// - time-out sets status bit 0 when queue level under threshold
// - time-out holds until the receive queue is read
// - event A: non-empty, max of 64us/four chars since load and read
// - event B: same with min interval, drives dma only
// - cir time-out: blocked while active, 64us after load, inactive, read
// - deferral: empty transmitter locks until queue holds 14 bytes
// - deferral timer reloads per write, releases lock after 64us idle
module cir_txrx (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // dma
  input wire logic i_dma_tc,
  output logic o_rx_dma_req,
  // interrupt line toward the host
  output logic o_rx_data_irq,
  // transceiver
  input wire logic i_ir_rx,
  output logic o_ir_tx
);

  logic [15:0] baud_div_ff;
  logic [7:0] ier_ff;
  logic [7:0] mcr_ff;
  logic [7:0] cfg_ff;
  logic [2:0] mode_ff;
  cir_pkg::carrier_cfg_t car_ff;
  cir_pkg::demod_cfg_t dem_ff;
  cir_pkg::mod_mode_t mmd_ff;
  logic eot_ff;
  logic underrun_ff;
  logic rx_active_ff;
  logic pulse_seen_ff;
  logic tout_flag_ff;

  logic [7:0] txq_mem [cir_pkg::QUEUE_DEPTH];
  logic [7:0] rxq_mem [cir_pkg::QUEUE_DEPTH];
  logic [3:0] txq_wp_ff, txq_rp_ff, rxq_wp_ff, rxq_rp_ff;
  logic [4:0] txq_cnt_ff, rxq_cnt_ff;

  wire logic wr_acc = i_psel & i_penable & i_pwrite;
  wire logic rd_acc = i_psel & i_penable & ~i_pwrite;
  wire logic cir_mode = (mode_ff[1:0] == cir_pkg::OPM_CIR);
  wire logic ext_mode = mode_ff[cir_pkg::MODE_EXT_BIT];
  wire logic tx_push = wr_acc & (i_paddr == cir_pkg::OFS_DATA) & (txq_cnt_ff != 5'h10);
  wire logic rx_pop = rd_acc & (i_paddr == cir_pkg::OFS_DATA) & (rxq_cnt_ff != 5'h00);
  wire logic asc_rd = rd_acc & (i_paddr == cir_pkg::OFS_AUX_STATUS);
  logic tx_pop, rx_push;
  logic [7:0] rx_push_byte;

  // ********************************************************************
  // baud enable
  // ********************************************************************
  logic [15:0] baud_cnt_ff;
  logic baud_tick;
  logic resync;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || resync || baud_cnt_ff >= baud_div_ff - 16'h0001) begin
      baud_cnt_ff <= 16'h0000;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + 16'h0001;
    end
  end
  assign baud_tick = (baud_cnt_ff == baud_div_ff - 16'h0001);

  // ********************************************************************
  // register file
  // ********************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      baud_div_ff <= cir_pkg::BAUD_DIV_RST;
      ier_ff <= 8'h00;
      mcr_ff <= 8'h00;
      cfg_ff <= 8'h00;
      mode_ff <= 3'h0;
      car_ff <= {cir_pkg::CARRIER_RST, 8'h08};
      dem_ff <= {8'h10, 8'h04};
      mmd_ff <= cir_pkg::MOD_CONT;
    end else if (wr_acc) begin
      unique case (i_paddr)
        cir_pkg::OFS_IRQ_ENABLE: ier_ff <= i_pwdata[7:0];
        cir_pkg::OFS_MODEM_CTRL: mcr_ff <= i_pwdata[7:0];
        cir_pkg::OFS_TX_CARRIER: car_ff <= i_pwdata[15:0];
        cir_pkg::OFS_CIR_CONFIG: begin
          cfg_ff <= i_pwdata[7:0];
          mmd_ff <= cir_pkg::mod_mode_t'(i_pwdata[9:8]);
        end
        cir_pkg::OFS_RX_DEMOD: dem_ff <= i_pwdata[15:0];
        cir_pkg::OFS_BAUD_DIV: baud_div_ff <= (i_pwdata[15:0] == 16'h0000) ? 16'h0001 : i_pwdata[15:0];
        cir_pkg::OFS_MODE: mode_ff <= i_pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & (i_paddr > cir_pkg::OFS_MODE | i_paddr[1:0] != 2'b00);
      unique case (i_paddr)
        cir_pkg::OFS_DATA: o_prdata <= {24'h0, rxq_mem[rxq_rp_ff]};
        cir_pkg::OFS_IRQ_ENABLE: o_prdata <= {24'h0, ier_ff};
        cir_pkg::OFS_MODEM_CTRL: o_prdata <= {24'h0, mcr_ff};
        cir_pkg::OFS_AUX_STATUS: o_prdata <= {27'h0, pulse_seen_ff, rx_active_ff, underrun_ff,
                                              eot_ff, tout_flag_ff};
        cir_pkg::OFS_TX_CARRIER: o_prdata <= {16'h0, car_ff};
        cir_pkg::OFS_CIR_CONFIG: o_prdata <= {22'h0, mmd_ff, cfg_ff};
        cir_pkg::OFS_RX_DEMOD: o_prdata <= {16'h0, dem_ff};
        cir_pkg::OFS_BAUD_DIV: o_prdata <= {16'h0, baud_div_ff};
        cir_pkg::OFS_MODE: o_prdata <= {29'h0, mode_ff};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************************
  // queues
  // ********************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (tx_push) begin
      txq_mem[txq_wp_ff] <= i_pwdata[7:0];
    end
    if (rx_push) begin
      rxq_mem[rxq_wp_ff] <= rx_push_byte;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      txq_wp_ff <= 4'h0;
      txq_rp_ff <= 4'h0;
      txq_cnt_ff <= 5'h00;
      rxq_wp_ff <= 4'h0;
      rxq_rp_ff <= 4'h0;
      rxq_cnt_ff <= 5'h00;
    end else begin
      txq_wp_ff <= txq_wp_ff + 4'(tx_push);
      txq_rp_ff <= txq_rp_ff + 4'(tx_pop);
      txq_cnt_ff <= txq_cnt_ff + 5'(tx_push) - 5'(tx_pop);
      rxq_wp_ff <= rxq_wp_ff + 4'(rx_push);
      rxq_rp_ff <= rxq_rp_ff + 4'(rx_pop);
      rxq_cnt_ff <= rxq_cnt_ff + 5'(rx_push) - 5'(rx_pop);
    end
  end

  // ********************************************************************
  // transmit deferral
  // ********************************************************************
  logic defer_lock_ff;
  logic [13:0] defer_cnt_ff;
  wire logic defer_on = ext_mode & cfg_ff[cir_pkg::CFG_TXQ_EN_BIT] & mcr_ff[cir_pkg::MCR_DEFER_BIT];
  logic tx_empty;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !defer_on) begin
      defer_lock_ff <= 1'b0;
      defer_cnt_ff <= 14'h0000;
    end else if (defer_lock_ff) begin
      if (txq_cnt_ff >= cir_pkg::TX_DEFER_LEVEL) begin
        defer_lock_ff <= 1'b0;
      end else if (tx_push || txq_cnt_ff == 5'h00) begin
        defer_cnt_ff <= 14'h0000;
      end else if (defer_cnt_ff == 14'(cir_pkg::TOUT_CYC - 1)) begin
        defer_lock_ff <= 1'b0;
      end else begin
        defer_cnt_ff <= defer_cnt_ff + 14'h0001;
      end
    end else if (tx_empty && txq_cnt_ff == 5'h00) begin
      defer_lock_ff <= 1'b1;
      defer_cnt_ff <= 14'h0000;
    end
  end

  // ********************************************************************
  // transmitter
  // ********************************************************************
  cir_pkg::tx_state_t tx_st_ff;
  logic [7:0] tx_sh_ff;
  logic [6:0] tx_run_ff;
  logic [2:0] tx_bits_ff;
  logic tx_bit_ff;
  logic tx_last_ff;
  assign tx_empty = (tx_st_ff == cir_pkg::TX_IDLE);
  wire logic rlc = cfg_ff[cir_pkg::CFG_RLC_BIT];
  wire logic unit_done = rlc ? (tx_run_ff == 7'h00) : (tx_bits_ff == 3'h7);
  wire logic can_load = (txq_cnt_ff != 5'h00) & ~defer_lock_ff;
  // queued bytes always follow on; the end marker only counts once the queue is dry
  assign tx_pop = cir_mode & baud_tick & can_load & ((tx_st_ff == cir_pkg::TX_IDLE) |
                  (tx_st_ff == cir_pkg::TX_SHIFT & unit_done));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      eot_ff <= 1'b0;
    end else if (wr_acc && i_paddr == cir_pkg::OFS_AUX_STATUS) begin
      eot_ff <= i_pwdata[cir_pkg::ASC_EOT_BIT];
    end else if (tx_push) begin
      eot_ff <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_st_ff <= cir_pkg::TX_IDLE;
      tx_sh_ff <= 8'hFF;
      tx_run_ff <= 7'h00;
      tx_bits_ff <= 3'h0;
      tx_bit_ff <= 1'b1;
      tx_last_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end else begin
      if (wr_acc && i_paddr == cir_pkg::OFS_AUX_STATUS && i_pwdata[cir_pkg::ASC_UNDERRUN_BIT]) begin
        underrun_ff <= 1'b0;
      end
      if (tx_pop) begin
        tx_sh_ff <= {1'b1, txq_mem[txq_rp_ff][7:1]};
        tx_bit_ff <= rlc ? txq_mem[txq_rp_ff][7] : txq_mem[txq_rp_ff][0];
        tx_run_ff <= txq_mem[txq_rp_ff][6:0];
        tx_bits_ff <= 3'h0;
        tx_st_ff <= cir_pkg::TX_SHIFT;
      end else if (cir_mode && baud_tick) begin
        unique case (tx_st_ff)
          cir_pkg::TX_IDLE: tx_bit_ff <= 1'b1;
          cir_pkg::TX_SHIFT: begin
            if (!unit_done) begin
              tx_run_ff <= tx_run_ff - 7'h01;
              tx_bits_ff <= tx_bits_ff + 3'h1;
              if (!rlc) begin
                tx_bit_ff <= tx_sh_ff[0];
                tx_sh_ff <= {1'b1, tx_sh_ff[7:1]};
              end
            end else if (tx_last_ff) begin
              tx_st_ff <= cir_pkg::TX_IDLE;
              tx_last_ff <= 1'b0;
              tx_bit_ff <= 1'b1;
            end else begin
              tx_st_ff <= cir_pkg::TX_UNDERRUN;
              underrun_ff <= 1'b1;
              tx_bit_ff <= 1'b1;
            end
          end
          cir_pkg::TX_UNDERRUN: begin
            if (!underrun_ff) begin
              tx_st_ff <= cir_pkg::TX_IDLE;
            end
          end
          default: tx_st_ff <= cir_pkg::TX_IDLE;
        endcase
      end
      // a marker written as the old frame closes belongs to the next one, so set wins
      if (tx_push && (eot_ff || i_dma_tc)) begin
        tx_last_ff <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // carrier modulator, only modulated output exists
  // ********************************************************************
  logic [9:0] car_cnt_ff;
  logic [3:0] burst_ff;
  logic prev_bit_ff;
  // high-speed carrier counts the field in single clocks, otherwise in fours
  wire logic [9:0] car_period = cfg_ff[cir_pkg::CFG_HSC_BIT] ?
                                {2'b00, car_ff.carrier_freq_sel} :
                                {car_ff.carrier_freq_sel, 2'b00};
  wire logic car_wrap = (car_cnt_ff >= car_period - 10'h001);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tx_bit_ff) begin
      car_cnt_ff <= 10'h000;
    end else begin
      car_cnt_ff <= car_wrap ? 10'h000 : car_cnt_ff + 10'h001;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      prev_bit_ff <= 1'b1;
      burst_ff <= 4'h0;
    end else begin
      prev_bit_ff <= tx_bit_ff;
      if (tx_bit_ff) begin
        burst_ff <= 4'h0;
      end else if (prev_bit_ff) begin
        burst_ff <= (mmd_ff == cir_pkg::MOD_EIGHT) ? 4'h8 : 4'h6;
      end else if (car_wrap && burst_ff != 4'h0) begin
        burst_ff <= burst_ff - 4'h1;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ir_tx <= 1'b0;
    end else begin
      o_ir_tx <= ~tx_bit_ff & (car_cnt_ff < 10'(car_ff.carrier_pulse_width)) &
                 ((mmd_ff == cir_pkg::MOD_CONT) | (burst_ff != 4'h0) | prev_bit_ff);
    end
  end

  // ********************************************************************
  // receiver
  // ********************************************************************
  logic ir_prev_ff;
  logic [9:0] rx_per_ff;
  logic in_band_ff;
  wire logic ir_rise = i_ir_rx & ~ir_prev_ff;
  wire logic [9:0] band_lo = {2'b00, dem_ff.demod_freq_range} - {2'b00, dem_ff.demod_bandwidth};
  wire logic [9:0] band_hi = {2'b00, dem_ff.demod_freq_range} + {2'b00, dem_ff.demod_bandwidth};
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ir_prev_ff <= 1'b0;
      rx_per_ff <= 10'h000;
      in_band_ff <= 1'b0;
    end else begin
      ir_prev_ff <= i_ir_rx;
      if (ir_rise) begin
        rx_per_ff <= 10'h000;
        in_band_ff <= (rx_per_ff >= band_lo) & (rx_per_ff <= band_hi);
      end else if (rx_per_ff != 10'h3FF) begin
        rx_per_ff <= rx_per_ff + 10'h001;
      end else begin
        in_band_ff <= 1'b0;
      end
    end
  end
  wire logic demod = cfg_ff[cir_pkg::CFG_DEMOD_EN_BIT];
  wire logic energy = demod ? in_band_ff : i_ir_rx;
  logic energy_prev_ff;
  assign resync = cir_mode & cfg_ff[cir_pkg::CFG_TPERIOD_BIT] & energy & ~energy_prev_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_active_ff <= 1'b0;
      pulse_seen_ff <= 1'b0;
      energy_prev_ff <= 1'b0;
    end else begin
      energy_prev_ff <= energy;
      if (cir_mode && energy) begin
        rx_active_ff <= 1'b1;
      end else if (wr_acc && i_paddr == cir_pkg::OFS_AUX_STATUS &&
                   i_pwdata[cir_pkg::ASC_RX_ACTIVE_FLAG_BIT]) begin
        rx_active_ff <= 1'b0;
      end
      if (ir_rise) begin
        pulse_seen_ff <= 1'b1;
      end else if (asc_rd) begin
        pulse_seen_ff <= 1'b0;
      end
    end
  end

  logic [7:0] rx_sh_ff;
  logic [2:0] rx_n_ff;
  logic rx_lvl_ff;
  logic [6:0] rx_run_ff;
  logic rx_push_ff;
  logic [7:0] rx_byte_ff;
  wire logic smp = ~energy;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_sh_ff <= 8'h00;
      rx_n_ff <= 3'h0;
      rx_lvl_ff <= 1'b1;
      rx_run_ff <= 7'h00;
      rx_push_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_push_ff <= 1'b0;
      if (rx_active_ff && baud_tick) begin
        if (!rlc) begin
          rx_sh_ff <= {smp, rx_sh_ff[7:1]};
          rx_n_ff <= rx_n_ff + 3'h1;
          if (rx_n_ff == 3'h7) begin
            rx_push_ff <= 1'b1;
            rx_byte_ff <= {smp, rx_sh_ff[7:1]};
          end
        end else if (smp != rx_lvl_ff || rx_run_ff == 7'h7F) begin
          rx_push_ff <= 1'b1;
          rx_byte_ff <= {rx_lvl_ff, rx_run_ff};
          rx_lvl_ff <= smp;
          rx_run_ff <= 7'h00;
        end else begin
          rx_run_ff <= rx_run_ff + 7'h01;
        end
      end
    end
  end
  assign rx_push = rx_push_ff & (rxq_cnt_ff != 5'h10);
  assign rx_push_byte = rx_byte_ff;

  // ********************************************************************
  // receive queue time-outs
  // ********************************************************************
  logic [13:0] inact_ff;
  logic [15:0] char_cyc;
  always_comb begin
    char_cyc = 16'(baud_div_ff * 16'(cir_pkg::CHAR_BITS * 4));
  end
  wire logic [15:0] tmin = (char_cyc < 16'(cir_pkg::TOUT_CYC)) ? char_cyc : 16'(cir_pkg::TOUT_CYC);
  wire logic [15:0] tmax = (char_cyc < 16'(cir_pkg::TOUT_CYC)) ? 16'(cir_pkg::TOUT_CYC) : char_cyc;
  logic [15:0] sl_ff, sr_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || rx_push) begin
      sl_ff <= 16'h0000;
    end else if (sl_ff != 16'hFFFF) begin
      sl_ff <= sl_ff + 16'h0001;
    end
    if (i_rst || rx_pop) begin
      sr_ff <= 16'h0000;
    end else if (sr_ff != 16'hFFFF) begin
      sr_ff <= sr_ff + 16'h0001;
    end
    if (i_rst || rx_active_ff) begin
      inact_ff <= 14'h0000;
    end else if (inact_ff != 14'h3FFF) begin
      inact_ff <= inact_ff + 14'h0001;
    end
  end
  wire logic nonempty = (rxq_cnt_ff != 5'h00);
  wire logic ev_a = nonempty & (sl_ff > tmax) & (sr_ff > tmax);
  wire logic ev_b = nonempty & (sl_ff > tmin) & (sr_ff > tmin);
  wire logic ev_c = nonempty & ~rx_active_ff & (sl_ff >= 16'(cir_pkg::TOUT_CYC)) &
                    (inact_ff >= 14'(cir_pkg::TOUT_CYC)) & (sr_ff > 16'(cir_pkg::TOUT_CYC));
  logic tout_a_ff, tout_b_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || rx_pop) begin
      tout_a_ff <= 1'b0;
      tout_b_ff <= 1'b0;
      tout_flag_ff <= 1'b0;
    end else begin
      if (cir_mode ? ev_c : ev_a) begin
        tout_a_ff <= 1'b1;
        tout_flag_ff <= tout_flag_ff | (rxq_cnt_ff < 5'(cir_pkg::RX_THRESH));
      end
      if (cir_mode ? ev_c : ev_b) begin
        tout_b_ff <= 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rx_data_irq <= 1'b0;
      o_rx_dma_req <= 1'b0;
    end else begin
      o_rx_data_irq <= tout_a_ff & ier_ff[0];
      o_rx_dma_req <= tout_b_ff & ext_mode & mcr_ff[cir_pkg::MCR_DMA_EN_BIT];
    end
  end

endmodule

// >>> cir_txrx_sva.sv
`timescale 1ns/100ps
// ****************
// port timing and hold checks
// ****************
module cir_txrx_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_rx_dma_req,
  input wire logic o_rx_data_irq,
  input wire logic o_ir_tx
);
  // two cycles of slack: the flag is registered after the timer
  localparam int GAP_MIN = cir_pkg::TOUT_CYC - 2;
  logic [15:0] gap_ff;
  logic [10:0] on_ff;
  logic rd_data;
  assign rd_data = i_psel && i_penable && !i_pwrite && i_paddr == cir_pkg::OFS_DATA;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || rd_data) gap_ff <= 16'h0;
    else if (gap_ff != 16'hFFFF) gap_ff <= gap_ff + 16'h1;
  end
  // a lit emitter must be chopped by the carrier
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !o_ir_tx) on_ff <= 11'h0;
    else if (on_ff != 11'h7FF) on_ff <= on_ff + 11'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ready_has_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("pready without a setup cycle");
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no pready after setup");
  ready_one_cycle_a: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  error_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  // the flag clears at the read edge, the registered line one edge later
  irq_holds_a: assert property ($fell(o_rx_data_irq) |-> $past(rd_data, 2))
    else $error("irq dropped without a data read");
  dma_holds_a: assert property ($fell(o_rx_dma_req) |-> $past(rd_data, 2))
    else $error("dma request dropped without a data read");
  irq_read_gap_a: assert property ($rose(o_rx_data_irq) |-> gap_ff >= GAP_MIN)
    else $error("irq too soon after a read");
  tx_modulated_a: assert property (on_ff != 11'h7FF)
    else $error("emitter lit without carrier");
endmodule

// >>> cir_ir_model.sv
`timescale 1ns/100ps
// ****************
// transceiver: carrier bursts in, emitter pulses counted
// ****************
module cir_ir_model (
  input wire logic i_clk_sys,
  input wire logic i_send,
  input wire logic i_clr,
  input wire logic i_ir_tx,
  output logic o_ir_rx,
  output logic [31:0] o_pulses
);
  logic [2:0] ph_ff = 3'h0;
  logic led_ff = 1'h0;
  // the detector output is dark, so low, outside a burst
  always_ff @(posedge i_clk_sys) begin
    ph_ff <= ph_ff + 3'h1;
    o_ir_rx <= i_send && ph_ff[2];
  end
  always_ff @(posedge i_clk_sys) begin
    led_ff <= i_ir_tx;
    if (i_clr) o_pulses <= 32'h0;
    else if (i_ir_tx && !led_ff) o_pulses <= o_pulses + 32'h1;
  end
endmodule

// >>> cir_txrx_test.sv
`timescale 1ns/100ps
// ****************
// bench
// ****************
module cir_txrx_test;
  logic i_clk_sys, irq, dma, ir_rx, ir_tx, pready, pslverr, er;
  logic i_rst = 1'h1, clr = 1'h1, send = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic tc = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, pulses;
  int fail_count = 0;
  int checks_done = 0;
  cir_pkg::mod_mode_t mods [3] = '{cir_pkg::MOD_CONT, cir_pkg::MOD_SIX, cir_pkg::MOD_EIGHT};
  logic [31:0] want [3] = '{32'h1, 32'h6, 32'h8};
  cir_txrx dut (.i_clk_sys, .i_rst, .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_dma_tc(tc), .o_rx_dma_req(dma), .o_rx_data_irq(irq),
    .i_ir_rx(ir_rx), .o_ir_tx(ir_tx));
  cir_ir_model ir (.i_clk_sys, .i_send(send), .i_clr(clr), .i_ir_tx(ir_tx),
    .o_ir_rx(ir_rx), .o_pulses(pulses));
  initial begin
    i_clk_sys = 1'h0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'h1;
    do @(posedge i_clk_sys); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    bus(1'h0, cir_pkg::OFS_BAUD_DIV, 32'h0);
    chk(rd, {16'h0, cir_pkg::BAUD_DIV_RST});
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[4:0], 32'h0);
    bus(1'h0, 8'h24, 32'h0);
    chk(er, 1'h1);
    // ****************
    // transmit, one framed byte per modulation mode
    // ****************
    bus(1'h1, cir_pkg::OFS_MODE, 32'h7);
    bus(1'h1, cir_pkg::OFS_TX_CARRIER, 32'h0201);
    for (int i = 0; i < 3; i++) begin
      // middle pass sends one run code of eight zeros, last pass ends by terminal count
      bus(1'h1, cir_pkg::OFS_CIR_CONFIG, {22'h0, mods[i], 6'h0, i == 1, 1'h0});
      bus(1'h1, cir_pkg::OFS_AUX_STATUS, i == 2 ? 32'h0 : 32'h2);
      clr <= 1'h0;
      tc <= (i == 2);
      bus(1'h1, cir_pkg::OFS_DATA, i == 1 ? 32'h7 : 32'h0);
      tc <= 1'h0;
      repeat (400) @(posedge i_clk_sys);
      chk(i == 0 ? 32'(pulses > 32'h8) : pulses, want[i]);
      bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
      chk(rd[2], 1'h0);
      clr <= 1'h1;
    end
    bus(1'h1, cir_pkg::OFS_DATA, 32'h55);
    repeat (400) @(posedge i_clk_sys);
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[2], 1'h1);
    bus(1'h1, cir_pkg::OFS_AUX_STATUS, 32'h4);
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[2], 1'h0);
    // ****************
    // receive a burst, stop, then wait for the time-out
    // ****************
    bus(1'h1, cir_pkg::OFS_IRQ_ENABLE, 32'h1);
    bus(1'h1, cir_pkg::OFS_MODEM_CTRL, 32'h4);
    // demod window far from the model's 8-clock carrier: the burst must be ignored
    bus(1'h1, cir_pkg::OFS_RX_DEMOD, 32'h4004);
    bus(1'h1, cir_pkg::OFS_CIR_CONFIG, 32'h4);
    send <= 1'h1;
    repeat (100) @(posedge i_clk_sys);
    send <= 1'h0;
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[3], 1'h0);
    bus(1'h1, cir_pkg::OFS_CIR_CONFIG, 32'h0);
    send <= 1'h1;
    repeat (300) @(posedge i_clk_sys);
    send <= 1'h0;
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[4:3], 2'h3);
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[4], 1'h0);
    bus(1'h1, cir_pkg::OFS_AUX_STATUS, 32'h8);
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[3], 1'h0);
    for (int n = 0; n < 20000 && irq !== 1'h1; n++) @(posedge i_clk_sys);
    chk(irq, 1'h1);
    chk(dma, 1'h1);
    bus(1'h0, cir_pkg::OFS_AUX_STATUS, 32'h0);
    chk(rd[0], 1'h1);
    bus(1'h0, cir_pkg::OFS_DATA, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    chk(irq, 1'h0);
    // ****************
    // deferral: level 14 releases, a lone byte waits for the timer
    // ****************
    bus(1'h1, cir_pkg::OFS_CIR_CONFIG, 32'h10);
    clr <= 1'h1;
    bus(1'h1, cir_pkg::OFS_MODEM_CTRL, 32'h8);
    clr <= 1'h0;
    for (int i = 0; i < 13; i++) bus(1'h1, cir_pkg::OFS_DATA, 32'h0);
    repeat (200) @(posedge i_clk_sys);
    chk(pulses, 32'h0);
    bus(1'h1, cir_pkg::OFS_DATA, 32'h0);
    repeat (100) @(posedge i_clk_sys);
    chk(32'(pulses > 32'h0), 32'h1);
    repeat (2500) @(posedge i_clk_sys);
    bus(1'h1, cir_pkg::OFS_AUX_STATUS, 32'h4);
    // let the transmitter fall idle so the lock is set before the lone byte
    repeat (40) @(posedge i_clk_sys);
    clr <= 1'h1;
    bus(1'h1, cir_pkg::OFS_DATA, 32'h0);
    clr <= 1'h0;
    repeat (7000) @(posedge i_clk_sys);
    chk(pulses, 32'h0);
    repeat (1500) @(posedge i_clk_sys);
    chk(32'(pulses > 32'h0), 32'h1);
    stop_test();
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule
bind cir_txrx cir_txrx_sva sva (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_pready, .o_pslverr, .o_rx_dma_req, .o_rx_data_irq, .o_ir_tx);
